// *** core/eep_nvm_array.sv ***
// Purpose: Nonvolatile bank store with a registered read port.
// Assumes: One write and one read port on the controller clock.
// Notes: Contents are not touched by reset; they start as erased zeros.
`timescale 1ns/1ps
`default_nettype none

module eep_nvm_array #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 8
) (
   // Clock.
   input wire logic clock,
   // Write port.
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read port.
   input wire logic rdEn,
   input wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];

   // An all-zero word is a valid code word, so an erased part recalls clean.
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clock) begin
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end

endmodule

`default_nettype wire

// *** core/eep_nvm_ctrl.sv ***
// Purpose: EEPROM program, recall and ECC control behind the register port.
// Assumes: I2C slave on the same clock presents byte register accesses.
// Notes: Pins chip_enable, supply good and rail good are synchronised here.
//
// Function
// R01: Eight banks, every program writes all.
// R02: Power-up recall, then rail, then idle access.
// R03: Program accepted in idle, active, sleep.
// R04: Writing 0x02 to 0xFF starts programming.
// R05: Host stays silent for program time.
// R06: Low program supply fails write, sets flags.
// R07: Successful write reloads registers from store.
// R08: Busy during register load answers NACK.
// R09: Recall at power-on and chip_enable toggle.
// R10: Writing 0x01 to 0xFF starts software recall.
// R11: Per-bank ECC, generated and stored in bank.
// R12: Single error sets corrected and fault flag.
// R13: Double error sets flags, enters fault shutdown.
// R14: Fault flag 0x5E bit 4, write one clears.
// R15: Program voltage flag 0x85 bit 0 only.
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.svh"

module eep_nvm_ctrl #(
   parameter int NUM_BANKS = `EEP_NUM_BANKS,
   parameter int PROG_TIME_US = `EEP_PROG_TIME_US
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Pins.
   input wire logic chipEnable,
   input wire logic programSupplyOk,
   input wire logic ioRailGood,
   input wire logic regulatorOutputEnable,
   // Register port from the I2C slave.
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regAck,
   output logic regNack,
   // Test hook: bits flipped in every word as it is programmed.
   input wire logic [`EEP_CODE_BITS-1:0] eccFlipMask,
   // Status and power control.
   output logic ioRailEnable,
   output logic idlePowered,
   output logic faultShutdown,
   output logic regulatorOn,
   output eep_pkg::eep_state_t stateOut,
   output logic [NUM_BANKS-1:0] bankCorrected,
   output logic [NUM_BANKS-1:0] bankUncorrectable
);
   import eep_pkg::*;

   localparam int PROG_CYCLES = PROG_TIME_US * `EEP_CLOCK_MHZ;
   localparam int BW = $clog2(`EEP_NUM_BANKS);

   if (NUM_BANKS != `EEP_NUM_BANKS) begin : g_chk_banks
      $error("eep_nvm_ctrl: the store has exactly eight banks");
   end
   if (PROG_CYCLES < 1) begin : g_chk_time
      $error("eep_nvm_ctrl: program time must be at least one cycle");
   end

   function automatic eep_code_t eccEncode(input eep_data_t d);
      eep_code_t c;
      logic [`EEP_PARITY_BITS-1:0] par;
      int k;
      c = '0;
      par = '0;
      k = 0;
      for (int i = 1; i < `EEP_CODE_BITS; i++) begin
         if ((i & (i - 1)) != 0) begin
            c[i] = d[k];
            k++;
            for (int j = 0; j < `EEP_PARITY_BITS; j++) begin
               if (((i >> j) & 1) != 0) begin
                  par[j] = par[j] ^ d[k-1];
               end
            end
         end
      end
      for (int j = 0; j < `EEP_PARITY_BITS; j++) begin
         c[1 << j] = par[j];
      end
      c[0] = ^c[`EEP_CODE_BITS-1:1];
      return c;
   endfunction

   function automatic eep_dec_t eccDecode(input eep_code_t cw);
      eep_dec_t r;
      eep_code_t c;
      logic [`EEP_PARITY_BITS-1:0] syn;
      logic ovr;
      int k;
      c = cw;
      syn = '0;
      ovr = ^cw;
      k = 0;
      r = '0;
      for (int i = 1; i < `EEP_CODE_BITS; i++) begin
         if (cw[i]) begin
            syn = syn ^ `EEP_PARITY_BITS'(i);
         end
      end
      if (ovr && (int'(syn) < `EEP_CODE_BITS)) begin
         c[syn] = ~c[syn];
         r.single = 1'b1;
      end else if (ovr || (syn != '0)) begin
         r.double = 1'b1;
      end
      for (int i = 1; i < `EEP_CODE_BITS; i++) begin
         if ((i & (i - 1)) != 0) begin
            r.data[k] = c[i];
            k++;
         end
      end
      return r;
   endfunction

   // Two-flop synchronisers for the pins.
   logic [1:0] ceMeta_q, supMeta_q, railMeta_q, regEnMeta_q;
   logic ceSync_q, supSync_q, railSync_q, regEnSync_q;
   always_ff @(posedge clock) begin
      ceMeta_q <= {ceMeta_q[0], chipEnable};
      supMeta_q <= {supMeta_q[0], programSupplyOk};
      railMeta_q <= {railMeta_q[0], ioRailGood};
      regEnMeta_q <= {regEnMeta_q[0], regulatorOutputEnable};
   end
   assign ceSync_q = ceMeta_q[1];
   assign supSync_q = supMeta_q[1];
   assign railSync_q = railMeta_q[1];
   assign regEnSync_q = regEnMeta_q[1];

   eep_state_t state_q;
   logic [BW-1:0] bank_q;
   logic rdPhase_q, fromPower_q, dblSeen_q;
   logic [$clog2(PROG_CYCLES+1)-1:0] progCnt_q;
   logic [7:0] cust_q [`EEP_CUST_BYTES];
   logic nvmFault_q, progVolt_q;

   // Register port decode.
   logic access, accept, custHit, ctlWr, clrWr;
   logic [3:0] custIdx;
   assign access = regWrEn | regRdEn;
   assign accept = access && (state_q == EEP_READY); // R08
   assign custHit = (regAddr >= `EEP_ADDR_CUST_BASE) &&
      (regAddr < (`EEP_ADDR_CUST_BASE + 8'(`EEP_CUST_BYTES)));
   assign custIdx = 4'(regAddr - `EEP_ADDR_CUST_BASE);
   assign ctlWr = accept && regWrEn && (regAddr == `EEP_ADDR_CONTROL);
   assign clrWr = accept && regWrEn && (regAddr == `EEP_ADDR_NVM_FAULT) &&
      regWrData[`EEP_BIT_NVM_FAULT]; // R14

   // Recall consumes a bank on the cycle after its read is issued.
   logic consume, lastBank, supplyFail;
   eep_dec_t dec;
   eep_code_t rdWord;
   assign consume = (state_q == EEP_RECALL) && rdPhase_q;
   assign lastBank = (bank_q == BW'(NUM_BANKS - 1));
   assign dec = eccDecode(rdWord);
   assign supplyFail = (state_q == EEP_PROGRAM) && !supSync_q;

   eep_nvm_array #(
      .WIDTH(`EEP_CODE_BITS),
      .DEPTH(`EEP_NUM_BANKS)
   ) u_array (
      .clock(clock),
      .wrEn(state_q == EEP_WRITE),
      .wrAddr(bank_q),
      .wrData(eccEncode({cust_q[{bank_q, 1'b1}], cust_q[{bank_q, 1'b0}]})
         ^ eccFlipMask), // R11
      .rdEn((state_q == EEP_RECALL) && !rdPhase_q),
      .rdAddr(bank_q),
      .rdData(rdWord)
   );

   // Sequencer.
   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= EEP_OFF;
         bank_q <= '0;
         rdPhase_q <= 1'b0;
         fromPower_q <= 1'b1;
         dblSeen_q <= 1'b0;
         progCnt_q <= '0;
      end else if (!ceSync_q) begin
         state_q <= EEP_OFF; // R09
         fromPower_q <= 1'b1;
      end else begin
         unique case (state_q)
            EEP_OFF: begin
               state_q <= EEP_RECALL; // R02 R09
               bank_q <= '0;
               rdPhase_q <= 1'b0;
               dblSeen_q <= 1'b0;
            end
            EEP_RECALL: begin
               rdPhase_q <= ~rdPhase_q;
               if (consume) begin
                  if (dec.double) begin
                     dblSeen_q <= 1'b1;
                  end
                  bank_q <= bank_q + 1'b1;
                  if (lastBank) begin
                     if (dblSeen_q || dec.double) begin
                        state_q <= EEP_FAULT; // R13
                     end else if (fromPower_q) begin
                        state_q <= EEP_RAMP; // R02
                     end else begin
                        state_q <= EEP_READY;
                     end
                  end
               end
            end
            EEP_RAMP: begin
               if (railSync_q) begin
                  state_q <= EEP_READY; // R02
                  fromPower_q <= 1'b0;
               end
            end
            EEP_READY: begin
               // Active and sleep are modes of this same powered state.
               if (ctlWr && (regWrData == `EEP_CMD_PROGRAM)) begin
                  state_q <= EEP_PROGRAM; // R03 R04
                  progCnt_q <= '0;
               end else if (ctlWr && (regWrData == `EEP_CMD_RECALL)) begin
                  state_q <= EEP_RECALL; // R10
                  bank_q <= '0;
                  rdPhase_q <= 1'b0;
                  dblSeen_q <= 1'b0;
               end
            end
            EEP_PROGRAM: begin
               // The host stays off the bus meanwhile; we NACK it anyway.
               if (supplyFail) begin
                  state_q <= EEP_READY; // R06
               end else if (int'(progCnt_q) == PROG_CYCLES - 1) begin
                  state_q <= EEP_WRITE; // R05
                  bank_q <= '0;
               end else begin
                  progCnt_q <= progCnt_q + 1'b1;
               end
            end
            EEP_WRITE: begin
               bank_q <= bank_q + 1'b1; // R01
               if (lastBank) begin
                  state_q <= EEP_RECALL; // R07
                  rdPhase_q <= 1'b0;
                  dblSeen_q <= 1'b0;
               end
            end
            EEP_FAULT: begin
               // Only a chip_enable toggle or power cycle leaves shutdown.
               state_q <= EEP_FAULT;
            end
         endcase
      end
   end

   // Customer registers: host writes, and recall loads from the banks.
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < `EEP_CUST_BYTES; i++) begin
            cust_q[i] <= `EEP_CUST_RESET;
         end
      end else if (consume) begin
         cust_q[{bank_q, 1'b0}] <= dec.data[7:0]; // R07 R09
         cust_q[{bank_q, 1'b1}] <= dec.data[15:8];
      end else if (accept && regWrEn && custHit) begin
         cust_q[custIdx] <= regWrData;
      end
   end

   // Fault flags: a new event wins over a clear in the same cycle.
   always_ff @(posedge clock) begin
      if (srst) begin
         nvmFault_q <= 1'b0;
         progVolt_q <= 1'b0;
         bankCorrected <= '0;
         bankUncorrectable <= '0;
      end else begin
         nvmFault_q <= (nvmFault_q & ~clrWr) | supplyFail |
            (consume & (dec.single | dec.double)); // R12 R13 R14
         progVolt_q <= (progVolt_q & ~clrWr) | supplyFail; // R06 R15
         for (int b = 0; b < NUM_BANKS; b++) begin
            bankCorrected[b] <= (bankCorrected[b] & ~clrWr) |
               (consume && dec.single && (int'(bank_q) == b)); // R12
            bankUncorrectable[b] <= (bankUncorrectable[b] & ~clrWr) |
               (consume && dec.double && (int'(bank_q) == b)); // R13
         end
      end
   end

   // Register port answers, one cycle after the request.
   always_ff @(posedge clock) begin
      if (srst) begin
         regAck <= 1'b0;
         regNack <= 1'b0;
         regRdData <= 8'h00;
      end else begin
         regAck <= accept;
         regNack <= access && !accept; // R08
         if (accept && regRdEn) begin
            if (custHit) begin
               regRdData <= cust_q[custIdx];
            end else if (regAddr == `EEP_ADDR_NVM_FAULT) begin
               regRdData <= 8'(nvmFault_q) << `EEP_BIT_NVM_FAULT; // R14
            end else if (regAddr == `EEP_ADDR_PROG_VOLT) begin
               regRdData <= 8'(progVolt_q) << `EEP_BIT_PROG_VOLT; // R15
            end else begin
               regRdData <= 8'h00;
            end
         end
      end
   end

   // Power and status outputs.
   always_ff @(posedge clock) begin
      if (srst) begin
         ioRailEnable <= 1'b0;
         idlePowered <= 1'b0;
         faultShutdown <= 1'b0;
         regulatorOn <= 1'b0;
         stateOut <= EEP_OFF;
      end else begin
         // The rail comes up only after a clean power-up load and stays up until fault shutdown or chip_enable low.
         ioRailEnable <= ceSync_q && (state_q != EEP_OFF) &&
            (state_q != EEP_FAULT) &&
            !((state_q == EEP_RECALL) && fromPower_q); // R02
         idlePowered <= (state_q == EEP_READY); // R02
         faultShutdown <= (state_q == EEP_FAULT); // R13
         regulatorOn <= regEnSync_q && (state_q == EEP_READY); // R13
         stateOut <= state_q;
      end
   end

endmodule

`default_nettype wire

// *** inc/eep_defines.svh ***
// Purpose: Shared constants of the EEPROM program and recall controller.
// Assumes: Byte-wide register port, eight banks of sixteen data bits.
// Notes: Offsets are register addresses seen by the I2C host.
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH

`define EEP_NUM_BANKS 8
`define EEP_BANK_DATA_BITS 16
`define EEP_CODE_BITS 22
`define EEP_PARITY_BITS 5

`define EEP_ADDR_NVM_FAULT 8'h5E
`define EEP_ADDR_PROG_VOLT 8'h85
`define EEP_ADDR_CONTROL 8'hFF
`define EEP_ADDR_CUST_BASE 8'h00
`define EEP_CUST_BYTES 16

`define EEP_BIT_NVM_FAULT 4
`define EEP_BIT_PROG_VOLT 0

`define EEP_CMD_RECALL 8'h01
`define EEP_CMD_PROGRAM 8'h02

`define EEP_CUST_RESET 8'h00
`define EEP_CLOCK_MHZ 50
`define EEP_PROG_TIME_US 5000

`endif

// *** inc/eep_pkg.sv ***
// Purpose: Types of the EEPROM program and recall controller.
// Assumes: Constants live in eep_defines.svh.
// Notes: The decoder result carries data and both error indications.
`include "eep_defines.svh"

package eep_pkg;

   typedef enum logic [2:0] {
      EEP_OFF,
      EEP_RECALL,
      EEP_RAMP,
      EEP_READY,
      EEP_PROGRAM,
      EEP_WRITE,
      EEP_FAULT
   } eep_state_t;

   typedef logic [`EEP_CODE_BITS-1:0] eep_code_t;
   typedef logic [`EEP_BANK_DATA_BITS-1:0] eep_data_t;

   typedef struct packed {
      eep_data_t data;
      logic single;
      logic double;
   } eep_dec_t;

endpackage

// *** verification/eep_host_model.sv ***
// Purpose: Host model issuing register accesses to the controller.
// Assumes: One-cycle request pulses, answer one cycle later.
// Notes: Released address and data are inverted so stale values never help.
`timescale 1ns/1ps
`default_nettype none

module eep_host_model (
   // Clock.
   input wire logic clock,
   // Requests.
   output logic regWrEn,
   output logic regRdEn,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   // Answers.
   input wire logic [7:0] regRdData,
   input wire logic regAck,
   input wire logic regNack
);
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
   end

   task automatic access(input logic wr, input logic [7:0] a,
         input logic [7:0] d, output logic [1:0] resp, output logic [7:0] rd);
      @(posedge clock);
      #1;
      regWrEn = wr;
      regRdEn = !wr;
      regAddr = a;
      regWrData = d;
      @(posedge clock);
      #1;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
      resp = {regNack, regAck};
      rd = regRdData;
   endtask
endmodule
`default_nettype wire

// *** verification/eep_nvm_ctrl_sva.sv ***
// Purpose: Port assertions of the EEPROM program and recall controller.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to the controller at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module eep_nvm_ctrl_sva #(
   parameter int NUM_BANKS = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic srst,
   // Pins.
   input wire logic chipEnable,
   input wire logic programSupplyOk,
   // Register port.
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regAck,
   input wire logic regNack,
   // Status.
   input wire logic ioRailEnable,
   input wire logic idlePowered,
   input wire logic faultShutdown,
   input wire logic regulatorOn,
   input wire logic [NUM_BANKS-1:0] bankUncorrectable
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   logic req;
   assign req = regWrEn || regRdEn;

   // Answer and idle flag both register the state seen at the request edge.
   sequence s_ctrl(logic [7:0] val);
      regWrEn && regAddr == 8'hFF && regWrData == val && idlePowered;
   endsequence

   a_busy_nack: assert property (req |=> regNack == !idlePowered)
      else $error("request outside idle was not refused");
   a_idle_ack: assert property (req |=> regAck == idlePowered)
      else $error("request in idle was not accepted");
   a_answer_cause: assert property ((regAck || regNack) |-> $past(req))
      else $error("answer without a request");
   a_rail_first: assert property ($rose(idlePowered) |-> ioRailEnable)
      else $error("idle reached with the io rail off");
   a_fault_off: assert property (
      faultShutdown |-> !regulatorOn && !idlePowered)
      else $error("fault shutdown still powered");
   a_fault_cause: assert property (
      $rose(faultShutdown) |-> ##[0:2] bankUncorrectable != '0)
      else $error("fault shutdown without a double error");
   a_prog_busy: assert property (
      s_ctrl(8'h02) ##0 programSupplyOk |=> regAck ##1 (!idlePowered) [*8])
      else $error("program command did not hold the device busy");
   a_prog_fail: assert property (
      s_ctrl(8'h02) ##0 !programSupplyOk |=> regAck ##[1:6] idlePowered)
      else $error("failed program did not return to idle");
   a_recall_busy: assert property (
      s_ctrl(8'h01) |=> regAck ##1 (!idlePowered) [*8] ##[1:30]
      (idlePowered || faultShutdown))
      else $error("recall command timing wrong");
   a_enable_off: assert property (
      !chipEnable [*5] |-> !idlePowered && !ioRailEnable)
      else $error("device still powered with chip enable low");
endmodule

bind eep_nvm_ctrl eep_nvm_ctrl_sva #(.NUM_BANKS(NUM_BANKS)) i_sva (
   .clock, .srst, .chipEnable, .programSupplyOk, .regWrEn, .regRdEn,
   .regAddr, .regWrData, .regAck, .regNack, .ioRailEnable, .idlePowered,
   .faultShutdown, .regulatorOn, .bankUncorrectable);
`default_nettype wire

// *** verification/eep_nvm_ctrl_test.sv ***
// Purpose: Self-checking bench of the EEPROM program and recall controller.
// Assumes: Program time cut to 2 us, so a write takes about 124 cycles.
// Notes: Host traffic goes through the partner model.
`timescale 1ns/1ps
`default_nettype none

module eep_nvm_ctrl_test;
   import eep_pkg::*;
   logic clock, srst, chipEnable, programSupplyOk, ioRailGood;
   logic regulatorOutputEnable, regWrEn, regRdEn, regAck, regNack;
   logic ioRailEnable, idlePowered, faultShutdown, regulatorOn;
   logic [7:0] regAddr, regWrData, regRdData, bankCorrected;
   logic [7:0] bankUncorrectable, rd;
   logic [21:0] eccFlipMask;
   logic [1:0] resp;
   logic [2:0] status;
   eep_state_t stateOut;
   localparam int W_RAIL = 0;
   localparam int W_IDLE = 1;
   localparam int W_FAULT = 2;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;

   eep_nvm_ctrl #(.PROG_TIME_US(2)) i_dut (.clock, .srst, .chipEnable,
      .programSupplyOk, .ioRailGood, .regulatorOutputEnable, .regWrEn,
      .regRdEn, .regAddr, .regWrData, .regRdData, .regAck, .regNack,
      .eccFlipMask, .ioRailEnable, .idlePowered, .faultShutdown,
      .regulatorOn, .stateOut, .bankCorrected, .bankUncorrectable);
   eep_host_model i_host (.clock, .regWrEn, .regRdEn, .regAddr,
      .regWrData, .regRdData, .regAck, .regNack);

   // Status outputs that the bench waits on, picked by index.
   assign status = {faultShutdown, idlePowered, ioRailEnable};

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // A hung handshake must still reach the verdict.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
      i_host.access(1'b1, a, d, resp, rd);
      check({6'h00, resp}, {6'h00, r});
   endtask

   task automatic rdchk(input logic [7:0] a, e);
      i_host.access(1'b0, a, 8'h00, resp, rd);
      check({6'h00, resp}, 8'h01);
      check(rd, e);
   endtask

   task automatic wait_for(input int sel, input int lim);
      for (int n = 0; n < lim && status[sel] !== 1'b1; n++) begin
         cyc(1);
      end
      check({7'h00, status[sel]}, 8'h01);
   endtask

   task automatic power_up();
      wr(8'h00, 8'h11, 2'h2);
      wait_for(W_RAIL, 60);
      check({7'h00, idlePowered}, 8'h00);
      ioRailGood = 1'b1;
      wait_for(W_IDLE, 20);
      check(8'(stateOut), 8'(EEP_READY));
   endtask

   task automatic prog();
      wr(8'hFF, 8'h02, 2'h1);
      cyc(4);
      wait_for(W_IDLE, 200);
   endtask

   initial begin
      srst = 1'b1;
      chipEnable = 1'b1;
      programSupplyOk = 1'b1;
      ioRailGood = 1'b0;
      regulatorOutputEnable = 1'b1;
      eccFlipMask = 22'h000000;
      cyc(5);
      srst = 1'b0;
      power_up();
      rdchk(8'h00, 8'h00);
      rdchk(8'h5E, 8'h00);
      rdchk(8'h85, 8'h00);
      rdchk(8'hFF, 8'h00);
      rdchk(8'h40, 8'h00);
      $display("test power_up done");
      for (int i = 0; i < 16; i++) begin
         wr(8'(i), 8'hA0 | 8'(i), 2'h1);
      end
      prog();
      for (int i = 0; i < 16; i++) begin
         wr(8'(i), 8'h00, 2'h1);
      end
      wr(8'hFF, 8'h01, 2'h1);
      wr(8'h00, 8'h55, 2'h2);
      wait_for(W_IDLE, 30);
      for (int i = 0; i < 16; i++) begin
         rdchk(8'(i), 8'hA0 | 8'(i));
      end
      $display("test program_recall done");
      programSupplyOk = 1'b0;
      cyc(4);
      wr(8'hFF, 8'h02, 2'h1);
      cyc(4);
      wait_for(W_IDLE, 20);
      rdchk(8'h85, 8'h01);
      rdchk(8'h5E, 8'h10);
      wr(8'h5E, 8'h10, 2'h1);
      rdchk(8'h85, 8'h00);
      rdchk(8'h5E, 8'h00);
      programSupplyOk = 1'b1;
      $display("test low_supply done");
      eccFlipMask = 22'h000008;
      prog();
      check(bankCorrected, 8'hFF);
      check(bankUncorrectable, 8'h00);
      rdchk(8'h05, 8'hA5);
      rdchk(8'h5E, 8'h10);
      rdchk(8'h85, 8'h00);
      wr(8'h5E, 8'h10, 2'h1);
      check(bankCorrected, 8'h00);
      $display("test single_error done");
      eccFlipMask = 22'h000000;
      wr(8'h07, 8'h00, 2'h1);
      // The rail reports not good while the device is off.
      chipEnable = 1'b0;
      ioRailGood = 1'b0;
      cyc(8);
      check({7'h00, ioRailEnable}, 8'h00);
      chipEnable = 1'b1;
      power_up();
      rdchk(8'h07, 8'hA7);
      $display("test chip_enable done");
      eccFlipMask = 22'h000018;
      check({7'h00, regulatorOn}, 8'h01);
      wr(8'hFF, 8'h02, 2'h1);
      cyc(4);
      wait_for(W_FAULT, 200);
      check(8'(stateOut), 8'(EEP_FAULT));
      check(bankUncorrectable, 8'hFF);
      check({7'h00, regulatorOn}, 8'h00);
      wr(8'h5E, 8'h10, 2'h2);
      $display("test double_error done");
      wrap_up();
   end
endmodule
`default_nettype wire
